// [core/acms_pkg.sv]
// Shared constants and types of the conversion-mode sequencer and its host.
// Assumes a 25 MHz aclk on both ends and a 16-bit serial frame.
`default_nettype none

package acms_pkg;

   // ==========================================================
   // Timing
   localparam int          CLK_MHZ     = 25;
   localparam int          GAP_NS      = 2000;   // Least select-end to strobe gap
   localparam int          GAP_CYC     = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int          CONV_NS     = 3500;   // Conversion time
   localparam int          CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int          SCLK_HALF   = 4;      // aclk cycles per half sclk period
   localparam int          CS_GAP      = 8;      // aclk cycles chip select stays high

   // ==========================================================
   // Frame and result store
   localparam int          RES_W       = 12;
   localparam int          FIFO_DEPTH  = 8;
   localparam logic [3:0]  CMD_CONFIG  = 4'hA;
   localparam logic [3:0]  CMD_RD_FIFO = 4'hE;

   // ==========================================================
   // Configuration register fields
   localparam int          THR_LSB     = 0;      // 00:8 01:6 10:4 11:2 entries
   localparam int          SEQ_LSB     = 2;      // Sweep length 2,4,6,8
   localparam int          MODE_LSB    = 5;
   localparam int          EXT_BIT     = 9;      // Strobe-controlled sampling
   localparam logic [11:0] CFG_RESET   = 12'h000;
   localparam logic [1:0]  MODE_ONESHOT = 2'h0;
   localparam logic [1:0]  MODE_REPEAT  = 2'h1;
   localparam logic [1:0]  MODE_SWEEP   = 2'h2;
   localparam logic [1:0]  MODE_RSWEEP  = 2'h3;

   // ==========================================================
   // Host register map (AXI4-Lite byte offsets)
   localparam logic [3:0]  A_CMD       = 4'h0;
   localparam logic [3:0]  A_STAT      = 4'h4;
   localparam logic [3:0]  A_RDATA     = 4'h8;
   localparam logic [3:0]  A_STRB      = 4'hC;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ==========================================================
   // State encodings
   typedef enum logic [2:0] {S_IDLE = 3'b001, S_SAMP = 3'b010, S_CONV = 3'b100} acms_dst_t;
   typedef enum logic [2:0] {H_IDLE = 3'b001, H_SHIFT = 3'b010, H_TAIL = 3'b100} acms_hst_t;

   // Fill level at which the threshold flag rises
   function automatic logic [3:0] acms_thr(input logic [11:0] cfg);
      return 4'(8 - 2 * int'(cfg[THR_LSB +: 2]));
   endfunction

   // Number of channels visited by one sweep
   function automatic logic [3:0] acms_len(input logic [11:0] cfg);
      return 4'(2 + 2 * int'(cfg[SEQ_LSB +: 2]));
   endfunction

endpackage

`default_nettype wire

// [core/acms_link_if.sv]
// Serial link between the converter sequencer and its host controller.
// Plain wires; each end samples what it receives through its own synchroniser.
`default_nettype none

interface acms_link_if;
   logic cs_n;                          // Chip select, low during a frame
   logic sclk;                          // Serial clock, made by the host
   logic sdi;                           // Host to device data
   logic sdo;                           // Device to host data
   logic conversion_start_strobe_n;     // Sampling/conversion strobe
   logic int_n;                         // Device interrupt, active low

   modport dev  (input cs_n, sclk, sdi, conversion_start_strobe_n, output sdo, int_n);
   modport host (output cs_n, sclk, sdi, conversion_start_strobe_n, input sdo, int_n);
endinterface

`default_nettype wire

// [core/acms_device.sv]
// Conversion-mode sequencer of the serial multichannel converter.
// Assumes the host keeps sdi steady around each sclk rise and sclk slow
// enough for a two-flop synchroniser (at least 8 aclk per period).
// Functional notes
// RQ1 - Repeat mode needs configuration then channel select
// RQ2 - Unread results lost on new select sequence
// RQ3 - Configuration held; reselect restarts repeat mode
// RQ4 - Host may strobe right after select command
// RQ5 - Strobed select samples only after chip select
// RQ6 - Gap of 2 us gives extra conversion
// RQ7 - Later samples started only by strobe
// RQ8 - Sweep converts listed channels in order
// RQ9 - Threshold cuts sweep short
// RQ10 - Interrupt when fill reaches threshold
// RQ11 - Sweep waits for read-out of results
// RQ12 - Repeat sweep continues past threshold
// RQ13 - Read after interrupt keeps results in order
// RQ14 - Other cycle or strobe clears store first
// RQ15 - Mode field: one-shot, repeat, sweep, repeat-sweep
// RQ16 - One-shot strobed: one interrupt per conversion
// RQ17 - Host selects next channel while reading result
// RQ18 - Repeat: interrupt served without read clears
// RQ19 - Strobe rise ends sampling, starts conversion
// RQ20 - Eight-entry store, threshold checked per result
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none

module acms_device
(
   input  wire logic                         aclk,         // System clock
   input  wire logic                         aresetn,      // Synchronous reset, low
   acms_link_if.dev                          link,         // Serial link to host
   input  wire logic [acms_pkg::RES_W-1:0]   analog_code,  // Converted value of channel_sel
   output logic      [2:0]                   channel_sel,  // Multiplexer channel
   output logic      [3:0]                   fifo_level    // Stored result count
);
   import acms_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0]                   sclk_s;   // [0] first flop, [2] edge history
      logic [2:0]                   cs_s;
      logic [2:0]                   stb_s;
      logic [1:0]                   sdi_s;
      logic [15:0]                  sh_in;
      logic [15:0]                  sh_out;
      logic [4:0]                   bits;
      logic                         sdo;
      logic                         int_n;
      logic [11:0]                  cfg;
      logic [2:0]                   chan;
      logic                         armed;
      logic                         sel_stb;
      logic                         thr_hit;
      logic                         clr_pend;
      logic                         hold;
      logic [6:0]                   gap;
      acms_dst_t                    st;
      logic [7:0]                   conv;
      logic [RES_W-1:0]             result;
      logic [FIFO_DEPTH-1:0][RES_W-1:0] mem;
      logic [2:0]                   wr;
      logic [2:0]                   rd;
      logic [3:0]                   cnt;
   } acms_dev_s_t;

   localparam acms_dev_s_t DEV_RST = '{cs_s: 3'h7, stb_s: 3'h7, int_n: 1'b1,
                                       cfg: CFG_RESET, st: S_IDLE, default: '0};

   acms_dev_s_t q;
   acms_dev_s_t d;
   logic [1:0]  mode;
   logic        ext;
   logic        sweeping;
   logic        sclk_rise;
   logic        cs_fall;
   logic        cs_rise;
   logic        cs_hi;
   logic        stb_fall;
   logic        stb_rise;
   logic [3:0]  cmd;

   // Empty the result store; contents are simply forgotten
   function automatic acms_dev_s_t fifo_flush(input acms_dev_s_t s);
      acms_dev_s_t r;
      r          = s;
      r.wr       = '0;
      r.rd       = '0;
      r.cnt      = '0;
      r.thr_hit  = 1'b0;
      r.clr_pend = 1'b0;
      return r;
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      d          = q;
      // Pins pass two flops; edges come from the second and third
      d.sclk_s   = {q.sclk_s[1:0], link.sclk};
      d.cs_s     = {q.cs_s[1:0], link.cs_n};
      d.stb_s    = {q.stb_s[1:0], link.conversion_start_strobe_n};
      d.sdi_s    = {q.sdi_s[0], link.sdi};
      mode       = q.cfg[MODE_LSB +: 2];                                   // RQ15
      ext        = q.cfg[EXT_BIT];
      sweeping   = (mode == MODE_SWEEP) || (mode == MODE_RSWEEP);
      sclk_rise  = q.sclk_s[1] & ~q.sclk_s[2];
      cs_fall    = ~q.cs_s[1] & q.cs_s[2];
      cs_rise    = q.cs_s[1] & ~q.cs_s[2];
      cs_hi      = q.cs_s[1];
      stb_fall   = ~q.stb_s[1] & q.stb_s[2];
      stb_rise   = q.stb_s[1] & ~q.stb_s[2];
      cmd        = q.sh_in[15:12];

      // Time since the last frame end, saturating
      if (q.gap != 7'(GAP_CYC))
      begin
         d.gap = q.gap + 7'h01;
      end

      // Frame start: load the word to send and retire the interrupt
      if (cs_fall)
      begin
         d.bits    = '0;
         d.sel_stb = 1'b0;
         d.int_n   = 1'b1;
         d.sh_out  = {4'h0, (mode == MODE_ONESHOT) ? q.result : q.mem[q.rd]};
         d.sdo     = 1'b0;                 // Leading nibble is always zero
      end
      else if (!cs_hi && sclk_rise)
      begin
         d.sh_in  = {q.sh_in[14:0], q.sdi_s[1]};
         d.sh_out = {q.sh_out[14:0], 1'b0};
         d.sdo    = q.sh_out[14];
         if (q.bits != 5'h10)
         begin
            d.bits = q.bits + 5'h01;
         end
      end

      // A strobe low once the command nibble is in is remembered
      if (!cs_hi && (q.bits >= 5'h04) && !q.stb_s[1])
      begin
         d.sel_stb = 1'b1;                                                 // RQ4
      end

      // Frame end: act on the command of a complete frame
      if (cs_rise && (q.bits == 5'h10))
      begin
         d.gap = '0;
         if (cmd == CMD_CONFIG)
         begin
            d       = fifo_flush(d);
            d.cfg   = q.sh_in[11:0];       // Kept until the next config RQ3
            d.armed = 1'b0;
            d.hold  = 1'b0;
            d.chan  = '0;
            d.st    = S_IDLE;
         end
         else if (cmd == CMD_RD_FIFO)
         begin
            // Reads drain in storage order; an empty store frees the sweep
            if (q.cnt != 4'h0)
            begin
               d.rd  = q.rd + 3'h1;                                        // RQ13
               d.cnt = q.cnt - 4'h1;
            end
            if (q.cnt <= 4'h1)
            begin
               d.thr_hit = 1'b0;
               d.hold    = 1'b0;                                           // RQ11
            end
         end
         else if (!cmd[3])
         begin
            // Channel select arms the sequence after configuration
            d.armed = 1'b1;                                                // RQ1 RQ3
            d.chan  = sweeping ? 3'h0 : cmd[2:0];
            if (ext)
            begin
               if (q.sel_stb && (q.st == S_IDLE) && !q.hold)
               begin
                  d.st = S_SAMP;                                           // RQ5
               end
            end
            else if ((q.st == S_IDLE) && !q.hold)
            begin
               d.st   = S_CONV;
               d.conv = '0;
            end
         end
         // After the threshold any cycle other than a read forfeits the data in repeat and repeat-sweep modes
         if (q.thr_hit && (cmd != CMD_RD_FIFO))
         begin
            if (mode == MODE_REPEAT)
            begin
               d = fifo_flush(d);                                          // RQ2 RQ18
            end
            else if (mode == MODE_RSWEEP)
            begin
               d.clr_pend = 1'b1;                                          // RQ14
            end
         end
      end

      // Strobe fall with chip select high opens sampling
      if (cs_hi && stb_fall && ext && q.armed && !q.hold && (q.st == S_IDLE))
      begin
         d.st = S_SAMP;                                                    // RQ7
         if ((mode == MODE_RSWEEP) && q.thr_hit)
         begin
            d.clr_pend = 1'b1;                                             // RQ14
         end
      end

      // Strobe rise ends sampling; too soon after the select it is dropped
      if ((q.st == S_SAMP) && cs_hi && stb_rise)
      begin
         if (q.gap == 7'(GAP_CYC))
         begin
            d.st   = S_CONV;                                               // RQ19 RQ6
            d.conv = '0;
         end
         else
         begin
            d.st = S_IDLE;
         end
      end

      // Conversion and storage of its result
      if (q.st == S_CONV)
      begin
         if (q.conv != 8'(CONV_CYC - 1))
         begin
            d.conv = q.conv + 8'h01;
         end
         else if (mode == MODE_ONESHOT)
         begin
            d.st     = S_IDLE;
            d.result = analog_code;
            d.int_n  = 1'b0;                                               // RQ16
            d.armed  = ext;                                                // RQ17
         end
         else
         begin
            d.st = S_IDLE;
            if (d.clr_pend)
            begin
               d = fifo_flush(d);                                          // RQ14
            end
            // A full store drops the new result rather than overwrite
            if (d.cnt != 4'(FIFO_DEPTH))
            begin
               d.mem[d.wr] = analog_code;
               d.wr        = d.wr + 3'h1;
               d.cnt       = d.cnt + 4'h1;
            end
            if (!d.thr_hit && (d.cnt >= acms_thr(q.cfg)))
            begin
               d.thr_hit = 1'b1;                                           // RQ20
               d.int_n   = 1'b0;                                           // RQ10
            end
            if (sweeping)
            begin
               if ((mode == MODE_SWEEP) && d.thr_hit)
               begin
                  d.hold = 1'b1;                                           // RQ9 RQ11
                  d.chan = '0;
               end
               else if ({1'b0, q.chan} + 4'h1 >= acms_len(q.cfg))
               begin
                  d.chan = '0;
                  d.hold = (mode == MODE_SWEEP);                           // RQ11
               end
               else
               begin
                  d.chan = q.chan + 3'h1;                                  // RQ8 RQ12
                  d.st   = S_CONV;
                  d.conv = '0;
               end
            end
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= DEV_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from state flops
   assign link.sdo   = q.sdo;
   assign link.int_n = q.int_n;
   assign channel_sel = q.chan;
   assign fifo_level  = q.cnt;

endmodule

`default_nettype wire

// [core/acms_host.sv]
// Host controller: software writes a 16-bit frame word over AXI4-Lite and
// this end shifts it out, making sclk by division of aclk.
// Assumes one AXI4-Lite master; sdo and int_n arrive asynchronously.
`default_nettype none

module acms_host
(
   input  wire logic        aclk,       // System clock
   input  wire logic        aresetn,    // Synchronous reset, low
   input  wire logic        awvalid,    // Write address valid
   output logic             awready,    // Write address ready
   input  wire logic [3:0]  awaddr,     // Write byte address
   input  wire logic        wvalid,     // Write data valid
   output logic             wready,     // Write data ready
   input  wire logic [31:0] wdata,      // Write data
   input  wire logic [3:0]  wstrb,      // Write byte lanes
   output logic             bvalid,     // Write response valid
   input  wire logic        bready,     // Write response ready
   output logic [1:0]       bresp,      // Write response
   input  wire logic        arvalid,    // Read address valid
   output logic             arready,    // Read address ready
   input  wire logic [3:0]  araddr,     // Read byte address
   output logic             rvalid,     // Read data valid
   input  wire logic        rready,     // Read data ready
   output logic [31:0]      rdata,      // Read data
   output logic [1:0]       rresp,      // Read response
   acms_link_if.host        link        // Serial link to the device
);
   import acms_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        aw_got;
      logic        w_got;
      logic [3:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [1:0]  sdo_s;
      logic [1:0]  int_s;
      acms_hst_t   st;
      logic [2:0]  div;
      logic [3:0]  bitn;
      logic [15:0] tx;
      logic [15:0] rx;
      logic [15:0] rword;
      logic        cs_n;
      logic        sclk;
      logic        sdi;
      logic        stb_n;
   } acms_hst_s_t;

   localparam acms_hst_s_t HST_RST = '{int_s: 2'h3, st: H_IDLE, cs_n: 1'b1,
                                       stb_n: 1'b1, default: '0};

   acms_hst_s_t q;
   acms_hst_s_t d;

   // Only the four word offsets answer OKAY
   function automatic logic addr_ok(input logic [3:0] a);
      return (a == A_CMD) || (a == A_STAT) || (a == A_RDATA) || (a == A_STRB);
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      d       = q;
      d.sdo_s = {q.sdo_s[0], link.sdo};
      d.int_s = {q.int_s[0], link.int_n};

      // Write address and data are caught in either order
      if (awvalid && q.awready)
      begin
         d.aw_got = 1'b1;
         d.awaddr = awaddr;
      end
      if (wvalid && q.wready)
      begin
         d.w_got = 1'b1;
         d.wdata = wdata;
         d.wstrb = wstrb;
      end
      if (q.bvalid && bready)
      begin
         d.bvalid = 1'b0;
      end
      if (d.aw_got && d.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = addr_ok(d.awaddr) ? RESP_OKAY : RESP_SLVERR;
         // A frame word while a frame runs is dropped; poll busy first
         if ((d.awaddr == A_CMD) && (d.wstrb[1:0] == 2'h3) && (q.st == H_IDLE))
         begin
            d.tx   = d.wdata[15:0];
            d.sdi  = d.wdata[15];
            d.cs_n = 1'b0;
            d.div  = '0;
            d.bitn = '0;
            d.st   = H_SHIFT;
         end
         if ((d.awaddr == A_STRB) && d.wstrb[0])
         begin
            d.stb_n = ~d.wdata[0];
         end
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;

      // Read channel
      if (q.rvalid && rready)
      begin
         d.rvalid = 1'b0;
      end
      if (arvalid && q.arready)
      begin
         d.rvalid = 1'b1;
         d.rresp  = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            A_STAT:  d.rdata = {29'h0, ~q.stb_n, ~q.int_s[1], q.st != H_IDLE};
            A_RDATA: d.rdata = {16'h0, q.rword};
            A_STRB:  d.rdata = {31'h0, ~q.stb_n};
            default: d.rdata = 32'h0;
         endcase
      end
      d.arready = !d.rvalid;

      // Frame engine: sdi changes on sclk fall, sdo sampled at each rise
      case (q.st)
         H_SHIFT:
         begin
            d.div = q.div + 3'h1;
            if (q.div == 3'(SCLK_HALF - 1))
            begin
               d.sclk = 1'b1;
               d.rx   = {q.rx[14:0], q.sdo_s[1]};
            end
            if (q.div == 3'(2 * SCLK_HALF - 1))
            begin
               d.sclk = 1'b0;
               d.tx   = {q.tx[14:0], 1'b0};
               d.sdi  = q.tx[14];
               d.bitn = q.bitn + 4'h1;
               if (q.bitn == 4'hF)
               begin
                  d.cs_n = 1'b1;
                  d.st   = H_TAIL;
               end
            end
         end
         H_TAIL:
         begin
            // Keeps chip select high long enough for the device to see it
            d.div = q.div + 3'h1;
            if (q.div == 3'(CS_GAP - 1))
            begin
               d.rword = q.rx;
               d.st    = H_IDLE;
            end
         end
         H_IDLE:  d.div = '0;
         default: d.st = H_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= HST_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from state flops
   assign awready = q.awready;
   assign wready  = q.wready;
   assign bvalid  = q.bvalid;
   assign bresp   = q.bresp;
   assign arready = q.arready;
   assign rvalid  = q.rvalid;
   assign rdata   = q.rdata;
   assign rresp   = q.rresp;
   assign link.cs_n = q.cs_n;
   assign link.sclk = q.sclk;
   assign link.sdi  = q.sdi;
   assign link.conversion_start_strobe_n = q.stb_n;

endmodule

`default_nettype wire

// [dv/acms_chk.sv]
// Link checker: frame shape and interrupt release between the two ends.
// Assumes the acms_link_if signals and one aclk domain.
`default_nettype none
module acms_chk
(
   input wire logic aclk,                      // Clock
   input wire logic aresetn,                   // Reset, low
   input wire logic cs_n,                      // Frame select
   input wire logic sclk,                      // Serial clock
   input wire logic sdi,                       // Host data
   input wire logic conversion_start_strobe_n, // Strobe
   input wire logic int_n                      // Interrupt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========
   // Frame shape
   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("sclk moves outside a frame");
   frame_len_a: assert property ($fell(cs_n) |-> ##127 !cs_n ##1 cs_n)
      else $error("frame length wrong");
   sclk_lead_a: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
      else $error("first sclk rise misplaced");
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("sclk high time wrong");
   sdi_hold_a: assert property ($rose(sclk) |-> $stable(sdi))
      else $error("sdi moved at sclk rise");
   cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("chip select gap short");
   // ==========
   // Interrupt release only by a new frame
   int_free_a: assert property ($fell(cs_n) && !int_n |-> ##[1:6] int_n)
      else $error("interrupt not released");
   int_rise_a: assert property ($rose(int_n) |-> !cs_n)
      else $error("interrupt released outside frame");
   cover property ($fell(int_n));
   cover property ($fell(conversion_start_strobe_n) && !cs_n);
   cover property ($rose(conversion_start_strobe_n) && cs_n);
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Bench: host controller and sequencer joined over the link.
// Assumes acms_pkg; drives AXI4-Lite and the analog input.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import acms_pkg::*;
   // ==========
   // Signals
   logic        aclk = 0, aresetn = 0, awready, wready, bvalid, arready, rvalid;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0]  awaddr = 0, araddr = 0, fifo_level;
   logic [31:0] wdata = 0, rdata, rv, seed = 32'hAC5F;
   logic [1:0]  bresp, rresp, rs;
   logic [11:0] analog_code = 0, tab [8], q [$];
   logic [2:0]  channel_sel;
   int          err_total = 0, checks_done = 0, cyc = 0;
   acms_link_if link ();
   acms_host acms_host_i (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .rvalid, .rready, .rdata, .rresp, .link);
   acms_device acms_device_i (.aclk, .aresetn, .link, .analog_code, .channel_sel,
      .fifo_level);
   acms_chk acms_chk_i (.aclk, .aresetn, .cs_n(link.cs_n), .sclk(link.sclk),
      .sdi(link.sdi), .conversion_start_strobe_n(link.conversion_start_strobe_n),
      .int_n(link.int_n));
   initial
      forever #20 aclk = ~aclk;
   // Analog value per channel; hang guard
   always @(posedge aclk)
   begin
      analog_code <= tab[channel_sel];
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_total++;
         end_sim();
      end
   end
   // ==========
   // Tasks
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Response is awaited with no assumed latency
   task automatic axw(logic [3:0] ad, logic [31:0] d);
      @(posedge aclk);
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= ad;
      wdata <= d;
      bready <= 1;
      forever
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 0;
   endtask
   task automatic axr(logic [3:0] ad);
      @(posedge aclk);
      arvalid <= 1;
      araddr <= ad;
      rready <= 1;
      forever
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      rv = rdata;
      rready <= 0;
   endtask
   // Poll busy, then fetch the answer word
   task automatic done();
      for (int n = 0; n < 100; n++)
      begin
         axr(A_STAT);
         if (rv[0] === 1'b0) break;
      end
      axr(A_RDATA);
   endtask
   task automatic frame(logic [15:0] w);
      axw(A_CMD, {16'h0, w});
      done();
   endtask
   task automatic wait_int();
      for (int i = 0; i < 3000 && link.int_n !== 1'b0; i++)
         @(posedge aclk);
   endtask
   task automatic pulse();
      repeat (60) @(posedge aclk);
      axw(A_STRB, 1);
      repeat (20) @(posedge aclk);
      axw(A_STRB, 0);
   endtask
   task automatic rst();
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========
   // Scenarios, each from a fresh reset
   initial
   begin
      foreach (tab[i]) tab[i] = 12'(xs());
      repeat (12) @(posedge aclk);
      rst();
      axw(4'h2, 0);
      chk("bresp", RESP_SLVERR, rs);
      frame(16'hA000);
      frame(16'h3000);
      wait_int();
      chk("int_n", 0, link.int_n);
      frame(16'h5000);
      chk("oneshot", tab[3], rv[15:0]);
      rst();
      frame(16'hA04A);
      frame(16'h0000);
      wait_int();
      repeat (200) @(posedge aclk);
      chk("stop", 4, fifo_level);
      q = {tab[0], tab[1], tab[2], tab[3]};
      repeat (4)
      begin
         frame(16'hE000);
         chk("sweep", q.pop_front(), rv[15:0]);
      end
      chk("empty", 0, fifo_level);
      rst();
      frame(16'hA06F);
      frame(16'h0000);
      wait_int();
      for (int i = 0; i < 2; i++)
      begin
         frame(16'hE000);
         chk("keep", tab[i], rv[15:0]);
      end
      repeat (800) @(posedge aclk);
      chk("full", 6, fifo_level);
      frame(16'h0000);
      for (int i = 0; i < 300 && fifo_level !== 4'h1; i++)
         @(posedge aclk);
      chk("flush", 1, fifo_level);
      rst();
      frame(16'hA223);
      axw(A_CMD, 32'h2000);
      repeat (40) @(posedge aclk);
      axw(A_STRB, 1);
      done();
      chk("held", 0, fifo_level);
      repeat (60) @(posedge aclk);
      axw(A_STRB, 0);
      repeat (120) @(posedge aclk);
      chk("first", 1, fifo_level);
      repeat (200) @(posedge aclk);
      chk("idle", 1, fifo_level);
      pulse();
      wait_int();
      chk("thr", 2, fifo_level);
      frame(16'h2000);
      chk("lost", 0, fifo_level);
      pulse();
      repeat (120) @(posedge aclk);
      chk("again", 1, fifo_level);
      end_sim();
   end
endmodule
`default_nettype wire
